// >>> lcm_bank.sv
// register bank: load-current measurement and power-good source select
`timescale 1ns/1ps
// Contract
// - each select write starts exactly one measurement
// - bits 1:0 pick regulator 0 to 3
// - master reports summed master and slave current
// - slave reports only its own current
// - low register holds result bits 7:0
// - high bits 9:8 in high register 1:0
// - 2-bit power-good source field per regulator
// - 0h excludes, 1h uses voltage threshold only
// - 3h needs voltage good and no current limit
module lcm_bank #(
    parameter int NUM_REG = lcm_pkg::LCM_NUM_REG,
    parameter int SAMPLE_CYC = lcm_pkg::LCM_SAMPLE_CYC,
    parameter int AVG_LOG2 = lcm_pkg::LCM_AVG_LOG2
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    output logic [7:0] reg_rdata,
    input wire logic [NUM_REG*10-1:0] phase_current,
    input wire logic [NUM_REG*2-1:0] phase_owner,
    input wire logic [NUM_REG-1:0] vout_ok,
    input wire logic [NUM_REG-1:0] ilim_active,
    output logic meas_busy,
    output logic power_good_output
);
    lcm_meas_if mif();

    logic [7:0] sel_q, sel_d;
    logic [7:0] pg_src_q, pg_src_d;
    logic [9:0] res_q, res_d;
    logic start_q, start_d;
    logic [7:0] rdata_d;

    // =========================================================
    // register writes
    // writes to the select register also fire a one-cycle start
    always_comb begin
        sel_d = sel_q;
        pg_src_d = pg_src_q;
        start_d = 1'b0;
        if (reg_wr && reg_addr == lcm_pkg::LCM_OFS_SELECT) begin
            sel_d = reg_wdata;
            start_d = 1'b1;
        end
        if (reg_wr && reg_addr == lcm_pkg::LCM_OFS_PG_SRC) begin
            pg_src_d = reg_wdata;
        end
    end

    // result pair updates together only on completion, so the two
    // bytes always come from one measurement
    always_comb begin
        res_d = res_q;
        if (mif.done) begin
            res_d = mif.result;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_q <= lcm_pkg::LCM_RST_SELECT;
            pg_src_q <= lcm_pkg::LCM_RST_PG_SRC;
            res_q <= lcm_pkg::LCM_RST_RESULT;
            start_q <= 1'b0;
        end else begin
            sel_q <= sel_d;
            pg_src_q <= pg_src_d;
            res_q <= res_d;
            start_q <= start_d;
        end
    end

    // =========================================================
    // measurement engine
    assign mif.start = start_q;
    assign mif.sel = sel_q[lcm_pkg::LCM_SEL_LSB +: lcm_pkg::LCM_SEL_W];

    lcm_meas #(
        .NUM_REG(NUM_REG),
        .SAMPLE_CYC(SAMPLE_CYC),
        .AVG_LOG2(AVG_LOG2)
    ) u_meas (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .mif(mif),
        .phase_current(phase_current),
        .phase_owner(phase_owner)
    );

    // =========================================================
    // power-good combine
    lcm_pg #(
        .NUM_REG(NUM_REG)
    ) u_pg (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pg_src(pg_src_q),
        .vout_ok(vout_ok),
        .ilim_active(ilim_active),
        .power_good_output(power_good_output)
    );

    // =========================================================
    // read mux; unmapped offsets read zero
    always_comb begin
        case (reg_addr)
            lcm_pkg::LCM_OFS_SELECT: rdata_d = sel_q;
            lcm_pkg::LCM_OFS_HIGH: rdata_d = {6'h00, res_q[9:8]};
            lcm_pkg::LCM_OFS_LOW: rdata_d = res_q[7:0];
            lcm_pkg::LCM_OFS_PG_SRC: rdata_d = pg_src_q;
            default: rdata_d = 8'h00;
        endcase
    end

    assign reg_rdata = rdata_d;
    assign meas_busy = mif.busy;
endmodule // lcm_bank

// >>> lcm_bank_chk.sv
// assertion checker for the load-current meter register slice
`timescale 1ns/1ps
module lcm_bank_chk #(
    parameter int NUM_REG = 4,
    parameter int SAMPLE_CYC = 100,
    parameter int AVG_LOG2 = 3
) (
    input logic sys_clk,
    input logic rst_n,
    input logic [7:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic reg_wr,
    input logic [7:0] reg_rdata,
    input logic [NUM_REG*10-1:0] phase_current,
    input logic [NUM_REG*2-1:0] phase_owner,
    input logic [NUM_REG-1:0] vout_ok,
    input logic [NUM_REG-1:0] ilim_active,
    input logic meas_busy,
    input logic power_good_output
);
    localparam int BUSY_MAX = 8 * SAMPLE_CYC + 8;
    localparam logic [7:0] A_SEL = lcm_pkg::LCM_OFS_SELECT;
    localparam logic [7:0] A_PG = lcm_pkg::LCM_OFS_PG_SRC;
    logic [7:0] pg_q, pg_d;
    logic pg_exp, sel_wr;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // =========================================================
    // shadow of the source field, so the combine can be predicted
    always_comb begin
        sel_wr = reg_wr && reg_addr == A_SEL;
        pg_d = (reg_wr && reg_addr == A_PG) ? reg_wdata : pg_q;
        pg_exp = 1'b1;
        for (int i = 0; i < NUM_REG; i++) begin
            if (pg_q[2*i+:2] == 2'h1) pg_exp &= vout_ok[i];
            if (pg_q[2*i+:2] == 2'h3) pg_exp &= vout_ok[i] & ~ilim_active[i];
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) pg_q <= 8'h00;
        else pg_q <= pg_d;
    end
    // =========================================================
    // properties
    property p_start; sel_wr |-> ##[1:3] meas_busy; endproperty
    property p_only_on_write;
        $rose(meas_busy) |->
            $past(sel_wr, 1) || $past(sel_wr, 2) || $past(sel_wr, 3);
    endproperty
    property p_ends; $rose(meas_busy) |-> ##[1:BUSY_MAX] !meas_busy;
    endproperty
    property p_high_rsvd;
        reg_addr == lcm_pkg::LCM_OFS_HIGH |-> reg_rdata[7:2] == 6'h00;
    endproperty
    property p_hold;
        reg_addr == lcm_pkg::LCM_OFS_LOW && $stable(reg_addr) && !meas_busy
            && !$past(meas_busy) && !$past(meas_busy, 2)
            |-> $stable(reg_rdata);
    endproperty
    property p_sel_back;
        sel_wr ##1 reg_addr == A_SEL |-> reg_rdata == $past(reg_wdata);
    endproperty
    property p_pg_back;
        reg_wr && reg_addr == A_PG ##1 reg_addr == A_PG
            |-> reg_rdata == $past(reg_wdata);
    endproperty
    property p_pg; $past(rst_n) |-> power_good_output == $past(pg_exp);
    endproperty
    a_start: assert property (p_start) else $error("no start");
    a_only_on_write: assert property (p_only_on_write)
        else $error("unrequested run");
    a_ends: assert property (p_ends) else $error("run hangs");
    a_high_rsvd: assert property (p_high_rsvd)
        else $error("high bits set");
    a_hold: assert property (p_hold) else $error("result moved");
    a_sel_back: assert property (p_sel_back)
        else $error("select readback");
    a_pg_back: assert property (p_pg_back)
        else $error("source readback");
    a_pg: assert property (p_pg) else $error("pg combine");
    c_start: cover property (sel_wr);
    c_done: cover property ($fell(meas_busy));
    c_pg_low: cover property ($fell(power_good_output));
endmodule // lcm_bank_chk
bind lcm_bank lcm_bank_chk #(.NUM_REG(NUM_REG), .SAMPLE_CYC(SAMPLE_CYC),
    .AVG_LOG2(AVG_LOG2)) u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rdata(reg_rdata), .phase_current(phase_current),
    .phase_owner(phase_owner), .vout_ok(vout_ok),
    .ilim_active(ilim_active), .meas_busy(meas_busy),
    .power_good_output(power_good_output));

// >>> lcm_meas.sv
// averaging load-current measurement engine
`timescale 1ns/1ps
module lcm_meas #(
    parameter int NUM_REG = 4,
    parameter int SAMPLE_CYC = lcm_pkg::LCM_SAMPLE_CYC,
    parameter int AVG_LOG2 = lcm_pkg::LCM_AVG_LOG2
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    lcm_meas_if.engine mif,
    input wire logic [NUM_REG*10-1:0] phase_current,
    input wire logic [NUM_REG*2-1:0] phase_owner
);
    typedef enum logic [1:0] {
        LCM_ST_IDLE = 2'b01,
        LCM_ST_RUN = 2'b10
    } lcm_state_t;

    localparam int ACC_W = 12 + AVG_LOG2;
    localparam int TICK_W = $clog2(SAMPLE_CYC + 1);

    lcm_state_t state_q, state_d;
    logic [1:0] sel_q, sel_d;
    logic [TICK_W-1:0] tick_q, tick_d;
    logic [AVG_LOG2:0] cnt_q, cnt_d;
    logic [ACC_W-1:0] acc_q, acc_d;
    logic done_q, done_d;
    logic [11:0] inst;
    logic [ACC_W-1:0] avg;
    logic [ACC_W-1:0] acc_next;

    // instantaneous sample: a master sums every phase it owns; a slave's owner
    // is its master, so a second term adds the selected slave's own phase
    always_comb begin
        inst = 12'h000;
        for (int i = 0; i < NUM_REG; i++) begin
            if (phase_owner[i*2 +: 2] == sel_q ||
                i[1:0] == sel_q && phase_owner[i*2 +: 2] != i[1:0] &&
                phase_owner[sel_q*2 +: 2] != sel_q) begin
                inst = inst + {2'h0, phase_current[i*10 +: 10]};
            end
        end
    end

    assign acc_next = acc_q + {{(ACC_W-12){1'b0}}, inst};
    assign avg = acc_next >> AVG_LOG2;

    // sequencer: a start restarts the average with the new selection
    always_comb begin
        state_d = state_q;
        sel_d = sel_q;
        tick_d = tick_q;
        cnt_d = cnt_q;
        acc_d = acc_q;
        done_d = 1'b0;
        case (state_q)
            LCM_ST_IDLE: begin
                if (mif.start) begin
                    state_d = LCM_ST_RUN;
                end
            end
            LCM_ST_RUN: begin
                if (tick_q == TICK_W'(SAMPLE_CYC - 1)) begin
                    tick_d = '0;
                    acc_d = acc_next;
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_q == (AVG_LOG2+1)'((1 << AVG_LOG2) - 1)) begin
                        state_d = LCM_ST_IDLE;
                        done_d = 1'b1;
                    end
                end else begin
                    tick_d = tick_q + 1'b1;
                end
            end
            default: state_d = LCM_ST_IDLE;
        endcase
        if (mif.start) begin
            sel_d = mif.sel;
            tick_d = '0;
            cnt_d = '0;
            acc_d = '0;
            done_d = 1'b0;
            state_d = LCM_ST_RUN;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= LCM_ST_IDLE;
            sel_q <= 2'h0;
            tick_q <= '0;
            cnt_q <= '0;
            acc_q <= '0;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            sel_q <= sel_d;
            tick_q <= tick_d;
            cnt_q <= cnt_d;
            acc_q <= acc_d;
            done_q <= done_d;
        end
    end

    // result saturates at full scale; latched by the bank on done
    logic [9:0] res_q, res_d;
    always_comb begin
        res_d = res_q;
        if (done_d) begin
            res_d = (avg > ACC_W'(lcm_pkg::LCM_RES_MAX)) ?
                lcm_pkg::LCM_RES_MAX : avg[9:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            res_q <= lcm_pkg::LCM_RST_RESULT;
        end else begin
            res_q <= res_d;
        end
    end

    assign mif.busy = (state_q == LCM_ST_RUN);
    assign mif.done = done_q;
    assign mif.result = res_q;
endmodule // lcm_meas

// >>> lcm_meas_if.sv
// handshake between register bank and measurement engine
`timescale 1ns/1ps
interface lcm_meas_if;
    logic start;
    logic [1:0] sel;
    logic busy;
    logic done;
    logic [9:0] result;

    modport bank (output start, output sel, input busy, input done,
        input result);
    modport engine (input start, input sel, output busy, output done,
        output result);
endinterface // lcm_meas_if

// >>> lcm_pg.sv
// per-regulator power-good source selection and combine
`timescale 1ns/1ps
module lcm_pg #(
    parameter int NUM_REG = 4
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [NUM_REG*2-1:0] pg_src,
    input wire logic [NUM_REG-1:0] vout_ok,
    input wire logic [NUM_REG-1:0] ilim_active,
    output logic power_good_output
);
    logic [NUM_REG-1:0] good;
    logic pg_q, pg_d;

    // reserved code 2h is never programmed; it is treated as masked
    // so a stray write cannot pull the output low
    for (genvar g = 0; g < NUM_REG; g++) begin : g_src
        always_comb begin
            case (pg_src[g*2 +: 2])
                lcm_pkg::LCM_PG_MASKED: good[g] = 1'b1;
                lcm_pkg::LCM_PG_VOLT: good[g] = vout_ok[g];
                lcm_pkg::LCM_PG_VOLT_ILIM:
                    good[g] = vout_ok[g] & ~ilim_active[g];
                default: good[g] = 1'b1;
            endcase
        end
    end

    assign pg_d = &good;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pg_q <= 1'b0;
        end else begin
            pg_q <= pg_d;
        end
    end

    assign power_good_output = pg_q;
endmodule // lcm_pg

// >>> lcm_pkg.sv
// shared constants for the load-current meter and power-good select slice
package lcm_pkg;
    // =========================================================
    // register offsets
    localparam logic [7:0] LCM_OFS_SELECT = 8'h25;
    localparam logic [7:0] LCM_OFS_HIGH = 8'h26;
    localparam logic [7:0] LCM_OFS_LOW = 8'h27;
    localparam logic [7:0] LCM_OFS_PG_SRC = 8'h28;

    // =========================================================
    // reset values
    localparam logic [7:0] LCM_RST_SELECT = 8'h00;
    localparam logic [7:0] LCM_RST_PG_SRC = 8'h00;
    localparam logic [9:0] LCM_RST_RESULT = 10'h000;

    // =========================================================
    // field layout
    localparam int LCM_SEL_LSB = 0;
    localparam int LCM_SEL_W = 2;
    localparam int LCM_RES_W = 10;
    localparam int LCM_HIGH_W = 2;
    localparam int LCM_PG_FIELD_W = 2;
    localparam int LCM_NUM_REG = 4;

    // full-scale code, 1023 x 20 mA = 20.46 A
    localparam logic [9:0] LCM_RES_MAX = 10'h3FF;
    localparam int LCM_LSB_MA = 20;

    // =========================================================
    // power-good source encodings
    typedef enum logic [1:0] {
        LCM_PG_MASKED = 2'h0,
        LCM_PG_VOLT = 2'h1,
        LCM_PG_RSVD = 2'h2,
        LCM_PG_VOLT_ILIM = 2'h3
    } lcm_pg_src_t;

    // =========================================================
    // measurement timing
    localparam int LCM_SAMPLE_US = 10;
    localparam int LCM_CLK_MHZ = 10;
    localparam int LCM_SAMPLE_CYC = LCM_SAMPLE_US * LCM_CLK_MHZ;
    localparam int LCM_AVG_LOG2 = 3;
endpackage

// >>> test_lcm_bank.sv
// self-checking bench for the load-current meter register slice
`timescale 1ns/1ps
module test_lcm_bank;
    localparam int SCYC = 4;
    logic sys_clk, rst_n, reg_wr, meas_busy, power_good_output;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [7:0] phase_owner = 8'hA0;
    logic [39:0] phase_current = {10'h1FF, 10'h300, 10'h0F0, 10'h123};
    logic [3:0] vout_ok, ilim_active;
    logic [9:0] exp_res [4] = '{10'h213, 10'h0F0, 10'h3FF, 10'h1FF};
    int err_count = 0, total_checks = 0, cycles = 0;
    // short sample period keeps each run at 32 cycles
    lcm_bank #(.SAMPLE_CYC(SCYC)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rdata(reg_rdata), .phase_current(phase_current),
        .phase_owner(phase_owner), .vout_ok(vout_ok),
        .ilim_active(ilim_active), .meas_busy(meas_busy),
        .power_good_output(power_good_output));
    // =========================================================
    // clock and hang guard
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            stop_test();
        end
    end
    // =========================================================
    // tasks
    task automatic stop_test();
        if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input string n, input logic [9:0] e,
        input logic [9:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        @(negedge sys_clk);
        v = reg_rdata;
    endtask
    task automatic measure(input logic [1:0] s, input logic [9:0] e);
        logic [7:0] hi, lo;
        wr(lcm_pkg::LCM_OFS_SELECT, {6'h2B, s});
        for (int n = 0; n < 5 && meas_busy !== 1'b1; n++) @(negedge sys_clk);
        for (int n = 0; n < 8 * SCYC + 9 && meas_busy !== 1'b0; n++)
            @(negedge sys_clk);
        repeat (3) @(posedge sys_clk);
        rd(lcm_pkg::LCM_OFS_HIGH, hi);
        rd(lcm_pkg::LCM_OFS_LOW, lo);
        check("result", e, {hi[1:0], lo});
        check("high_rsvd", 10'h000, {4'h0, hi[7:2]});
        rd(lcm_pkg::LCM_OFS_SELECT, lo);
        check("select", {2'h0, 6'h2B, s}, {2'h0, lo});
        // look at busy between edges so the flop has settled
        repeat (20) @(negedge sys_clk);
        check("idle", 10'h000, {9'h000, meas_busy});
    endtask
    // =========================================================
    // main sequence
    initial begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        vout_ok = 4'h0;
        ilim_active = 4'hF;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int a = 8'h24; a < 8'h2A; a++) begin
            rd(8'(a), d);
            check("reset_value", 10'h000, {2'h0, d});
        end
        check("pg_default", 10'h001, {9'h000, power_good_output});
        for (int s = 0; s < 4; s++) measure(2'(s), exp_res[s]);
        // inputs move and the low register is written, but no select write: the result must stay
        phase_current <= 40'h0;
        wr(lcm_pkg::LCM_OFS_LOW, 8'h55);
        repeat (SCYC * 10) @(posedge sys_clk);
        rd(lcm_pkg::LCM_OFS_LOW, d);
        check("held_low", 10'h0FF, {2'h0, d});
        // strangers on other regulators are driven to spoil the result
        for (int i = 0; i < 4; i++) begin
            for (int c = 0; c < 4; c++) begin
                if (c == 2) continue;
                wr(lcm_pkg::LCM_OFS_PG_SRC, 8'(c << (2 * i)));
                rd(lcm_pkg::LCM_OFS_PG_SRC, d);
                check("pg_src", 10'(c << (2 * i)), {2'h0, d});
                for (int v = 0; v < 4; v++) begin
                    @(posedge sys_clk);
                    vout_ok <= v[0] ? 4'h1 << i : 4'h0;
                    ilim_active <= v[1] ? 4'hF : ~(4'h1 << i);
                    @(posedge sys_clk);
                    @(negedge sys_clk);
                    check("pg_out", c == 0 ? 10'h1 : c == 1 ? 10'(v[0]) :
                        10'(v[0] & ~v[1]), {9'h0, power_good_output});
                end
            end
        end
        stop_test();
    end
endmodule // test_lcm_bank
